/* inc/wsc_pkg.sv */
// package of constants and encodings for the integer core access port
package wsc_pkg;
	localparam int ADDR_W = 32;
	localparam int STAT_W = 8;
	localparam logic [1:0] PH_IDLE = 2'h0;
	localparam logic [1:0] PH_STORE2 = 2'h1;
	localparam logic [1:0] PH_HOLD = 2'h2;
	localparam logic [1:0] PH_VOID = 2'h3;
	typedef enum logic [1:0] {
		WSC_RUN = 2'b00,
		WSC_STORE2 = 2'b01,
		WSC_HELD = 2'b10
	} wsc_state_t;
endpackage : wsc_pkg

/* rtl/wsc_prev_access.sv */
// access status history: previous issued access, captured from the current one
`timescale 1ns/10ps
`default_nettype none
module wsc_prev_access
	import wsc_pkg::*;
#(
	parameter int AW = wsc_pkg::ADDR_W,
	parameter int SW = wsc_pkg::STAT_W
)(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic advance,
	input wire logic [AW-1:0] cur_addr,
	input wire logic [SW-1:0] cur_stat,
	output logic [AW-1:0] prev_addr,
	output logic [SW-1:0] prev_stat
);
	initial
	begin
		if (AW < 1 || SW < 1)
			$error("wsc_prev_access: widths must be positive");
	end
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [SW-1:0] stat;
	} wsc_prev_t;
	wsc_prev_t st_reg;
	wsc_prev_t st_next;
	// capture only when the core moves to a fresh access
	always_comb
	begin
		st_next = st_reg;
		if (advance)
		begin
			st_next.addr = cur_addr;
			st_next.stat = cur_stat;
		end
	end
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign prev_addr = st_reg.addr;
	assign prev_stat = st_reg.stat;
endmodule : wsc_prev_access
`default_nettype wire

/* rtl/wsc_core_port.sv */
// integer core memory port: hold sampling, replay of previous access, store sequencing, void
`timescale 1ns/10ps
`default_nettype none
module wsc_core_port
	import wsc_pkg::*;
#(
	parameter int AW = wsc_pkg::ADDR_W,
	parameter int SW = wsc_pkg::STAT_W
)(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_store,
	input wire logic [AW-1:0] req_addr,
	input wire logic [SW-1:0] req_stat,
	input wire logic [31:0] req_wdata,
	input wire logic req_fault,
	input wire logic fpc_fault,
	input wire logic wait_hold_request,
	input wire logic replay_prev_access,
	input wire logic memory_data_strobe,
	input wire logic [31:0] bus_rdata,
	output logic [AW-1:0] bus_addr,
	output logic [SW-1:0] bus_stat,
	output logic bus_valid,
	output logic bus_write,
	output logic [31:0] bus_wdata,
	output logic core_void_access,
	output logic fpc_void_access,
	output logic core_stalled,
	output logic core_ready,
	output logic rdata_valid,
	output logic [31:0] rdata,
	output logic [1:0] phase
);
	initial
	begin
		if (AW != 32)
			$error("wsc_core_port: address path must be 32 bits");
		if (SW < 1)
			$error("wsc_core_port: status width must be positive");
	end
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		wsc_state_t fsm;
		logic [AW-1:0] addr;
		logic [SW-1:0] stat;
		logic valid;
		logic write;
		logic [31:0] wdata;
		logic cvoid;
		logic fvoid;
		logic stalled;
		logic ready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] phase;
		logic hold_armed;
	} wsc_port_t;
	wsc_port_t s_reg;
	wsc_port_t s_next;
	logic [AW-1:0] prev_addr;
	logic [SW-1:0] prev_stat;
	logic advance;
	// a valid access on the bus advances the history whenever the core is not held
	assign advance = s_reg.valid && !s_reg.stalled;
	wsc_prev_access #(
		.AW(AW),
		.SW(SW)
	) u_prev (
		.clock(clock),
		.sys_rst(sys_rst),
		.advance(advance),
		.cur_addr(s_reg.addr),
		.cur_stat(s_reg.stat),
		.prev_addr(prev_addr),
		.prev_stat(prev_stat)
	);
	////////////////////////////////////////////////////////////////////////
	// next-state: issue, store second cycle, hold, replay, strobe, void
	always_comb
	begin
		s_next = s_reg;
		s_next.rvalid = 1'b0;
		s_next.cvoid = req_fault;
		s_next.fvoid = fpc_fault;
		case (s_reg.fsm)
			WSC_RUN:
			begin
				// hold looks back at the access issued one cycle earlier
				if (s_reg.hold_armed && wait_hold_request)
				begin
					s_next.fsm = WSC_HELD;
					s_next.stalled = 1'b1;
					s_next.ready = 1'b0;
					s_next.phase = PH_HOLD;
				end
				else if (req_valid)
				begin
					s_next.addr = req_addr;
					s_next.stat = req_stat;
					s_next.valid = 1'b1;
					s_next.write = 1'b0;
					s_next.wdata = req_wdata;
					if (req_store)
					begin
						// first cycle only checks the address
						s_next.fsm = WSC_STORE2;
						s_next.ready = 1'b0;
						s_next.phase = PH_STORE2;
					end
					else
					begin
						s_next.ready = 1'b1;
						s_next.phase = PH_IDLE;
					end
				end
				else
				begin
					// an idle cycle must not repeat the last store's write
					s_next.valid = 1'b0;
					s_next.write = 1'b0;
					s_next.ready = 1'b1;
					s_next.phase = PH_IDLE;
				end
			end
			WSC_STORE2:
			begin
				// second cycle performs the write unless voided
				s_next.write = !(req_fault || fpc_fault);
				s_next.fsm = WSC_RUN;
				s_next.ready = 1'b1;
				s_next.phase = (req_fault || fpc_fault) ? PH_VOID : PH_IDLE;
			end
			WSC_HELD:
			begin
				s_next.write = 1'b0;
				// replay puts the displaced access back on the bus
				if (replay_prev_access)
				begin
					s_next.addr = prev_addr;
					s_next.stat = prev_stat;
				end
				// data strobe ends the hold, whatever the hold level
				if (memory_data_strobe)
				begin
					s_next.rvalid = 1'b1;
					s_next.rdata = bus_rdata;
					s_next.fsm = WSC_RUN;
					s_next.stalled = 1'b0;
					s_next.ready = 1'b1;
					s_next.valid = 1'b0;
					s_next.phase = PH_IDLE;
				end
				else if (!wait_hold_request)
				begin
					s_next.fsm = WSC_RUN;
					s_next.stalled = 1'b0;
					s_next.ready = 1'b1;
					s_next.valid = 1'b0;
					s_next.phase = PH_IDLE;
				end
			end
			default:
			begin
				s_next.fsm = WSC_RUN;
				s_next.stalled = 1'b0;
			end
		endcase
		// armed for the access issued now, so its hold is taken one cycle later
		s_next.hold_armed = s_next.valid && !s_next.stalled;
	end
	// synchronous reset to an idle, unstalled port
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			s_reg <= '0;
			s_reg.fsm <= WSC_RUN;
			s_reg.ready <= 1'b1;
		end
		else
			s_reg <= s_next;
	end
	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign bus_addr = s_reg.addr;
	assign bus_stat = s_reg.stat;
	assign bus_valid = s_reg.valid;
	assign bus_write = s_reg.write;
	assign bus_wdata = s_reg.wdata;
	assign core_void_access = s_reg.cvoid;
	assign fpc_void_access = s_reg.fvoid;
	assign core_stalled = s_reg.stalled;
	assign core_ready = s_reg.ready;
	assign rdata_valid = s_reg.rvalid;
	assign rdata = s_reg.rdata;
	assign phase = s_reg.phase;
	////////////////////////////////////////////////////////////////////////
	hold_stalls_a: assert property (@(posedge clock) disable iff (sys_rst)
		(s_reg.fsm == WSC_RUN && s_reg.hold_armed && wait_hold_request) |=> core_stalled && !core_ready)
		else $error("hold request did not stall the core");
	replay_drives_a: assert property (@(posedge clock) disable iff (sys_rst)
		(s_reg.fsm == WSC_HELD && replay_prev_access) |=> bus_addr == $past(prev_addr))
		else $error("replay did not restore previous address");
	store_two_a: assert property (@(posedge clock) disable iff (sys_rst)
		(s_reg.fsm == WSC_RUN && !(s_reg.hold_armed && wait_hold_request) && req_valid && req_store)
		|=> !bus_write ##1 (bus_write == !$past(req_fault || fpc_fault)))
		else $error("store did not write in its second cycle");
	void_follows_a: assert property (@(posedge clock) disable iff (sys_rst)
		(req_fault || fpc_fault) |=> (core_void_access == $past(req_fault)) && (fpc_void_access == $past(fpc_fault)))
		else $error("void signals did not follow their faults");
	strobe_release_a: assert property (@(posedge clock) disable iff (sys_rst)
		(s_reg.fsm == WSC_HELD && memory_data_strobe) |=> rdata_valid && !core_stalled ##1 !rdata_valid)
		else $error("data strobe did not release the hold");
	addr_fresh_a: assert property (@(posedge clock) disable iff (sys_rst)
		(s_reg.fsm == WSC_RUN && !(s_reg.hold_armed && wait_hold_request) && req_valid)
		|=> bus_valid && bus_addr == $past(req_addr))
		else $error("fresh access address not issued");
endmodule : wsc_core_port
`default_nettype wire

/* tb/wsc_slow_dev.sv */
// far-side slow device model: hold, replay request and data strobe
`timescale 1ns/10ps
`default_nettype none
module wsc_slow_dev (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [3:0] dly,
	input wire logic [31:0] bus_addr,
	input wire logic void_any,
	output logic stretched_clock,
	output logic wait_hold_request,
	output logic replay_prev_access,
	output logic memory_data_strobe,
	output logic [31:0] bus_rdata
);
	logic active_reg;
	logic [3:0] cnt_reg;
	logic [31:0] last_reg;
	logic hold_flag;
	logic first_count_stage;
	logic second_count_stage;
	// fixed two wait-state stretcher; start doubles as the decoded stretch request
	always_ff @(negedge clock)
	begin
		if (sys_rst || void_any)
			hold_flag <= 1'b0;
		else if (second_count_stage)
			hold_flag <= 1'b0;
		else if (start)
			hold_flag <= 1'b1;
	end
	// first stage follows the flag, so it drops once the flag has cleared
	always_ff @(posedge clock)
	begin
		first_count_stage <= hold_flag && !sys_rst;
		second_count_stage <= first_count_stage && !sys_rst;
	end
	// low phase held while the flag is set, free clock otherwise
	assign stretched_clock = clock & ~hold_flag;
	// hold rises with the slow access and stays until the data is strobed
	assign wait_hold_request = start | active_reg;
	assign replay_prev_access = active_reg;
	assign memory_data_strobe = active_reg && cnt_reg == dly;
	// released data lines show the inverse, so a stale word never matches
	assign bus_rdata = memory_data_strobe ? {bus_addr[15:0], bus_addr[31:16]} : ~last_reg;
	//////////////////////////////////////////////////////////////////////
	// wait counter; strobe lasts one cycle because it clears active
	always_ff @(posedge clock)
	begin
		last_reg <= bus_rdata;
		if (sys_rst || memory_data_strobe)
			active_reg <= 1'b0;
		else if (start)
			active_reg <= 1'b1;
		cnt_reg <= (active_reg && !start) ? cnt_reg + 4'h1 : 4'h0;
	end
endmodule : wsc_slow_dev
`default_nettype wire

/* tb/wsc_core_port_bench.sv */
// self-checking bench for the integer core memory port
`timescale 1ns/10ps
`default_nettype none
module wsc_core_port_bench;
	logic clock, sys_rst, req_valid, req_store, req_fault, fpc_fault, start;
	logic [31:0] req_addr, req_wdata, bus_addr, bus_wdata, rdata, bus_rdata;
	logic [7:0] req_stat, bus_stat;
	logic [3:0] dly;
	logic hold, replay, strobe, bus_valid, bus_write, core_void, fpc_void, stalled, ready, rvalid;
	logic [1:0] phase;
	logic stretched_clock;
	int sc_count = 0;
	int miscompares = 0;
	int check_count = 0;
	wsc_core_port i_wsc_core_port (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_store(req_store), .req_addr(req_addr), .req_stat(req_stat), .req_wdata(req_wdata),
		.req_fault(req_fault), .fpc_fault(fpc_fault), .wait_hold_request(hold),
		.replay_prev_access(replay), .memory_data_strobe(strobe), .bus_rdata(bus_rdata),
		.bus_addr(bus_addr), .bus_stat(bus_stat), .bus_valid(bus_valid), .bus_write(bus_write),
		.bus_wdata(bus_wdata), .core_void_access(core_void), .fpc_void_access(fpc_void),
		.core_stalled(stalled), .core_ready(ready), .rdata_valid(rvalid), .rdata(rdata), .phase(phase));
	wsc_slow_dev i_wsc_slow_dev (.clock(clock), .sys_rst(sys_rst), .start(start), .dly(dly),
		.bus_addr(bus_addr), .void_any(req_fault | fpc_fault), .stretched_clock(stretched_clock),
		.wait_hold_request(hold), .replay_prev_access(replay),
		.memory_data_strobe(strobe), .bus_rdata(bus_rdata));
	//////////////////////////////////////////////////////////////////////
	// rising edges that reach the stretched clock
	always @(posedge stretched_clock)
		sc_count++;
	// inputs always move one fixed delay after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h wanted %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk_word
	task automatic close_out();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	//////////////////////////////////////////////////////////////////////
	// back-to-back loads: a fresh address on the bus every cycle
	task automatic t_back();
		req_valid = 1'b1;
		req_addr = 32'h1000_0004;
		step(1);
		chk_word({bus_valid, bus_addr[30:0]}, 32'h9000_0004);
		chk_word({24'h0, bus_stat}, 32'h0000_000b);
		req_addr = 32'h2000_0008;
		step(1);
		chk_word(bus_addr, 32'h2000_0008);
		req_valid = 1'b0;
	endtask : t_back
	// held slow load: refused request, replayed address, strobe timing
	task automatic t_hold(input logic [3:0] d);
		int i;
		dly = d;
		req_valid = 1'b1;
		req_addr = 32'h5a5a_1234;
		step(1);
		req_valid = 1'b0;
		start = 1'b1;
		step(1);
		start = 1'b0;
		chk_word({stalled, ready, phase}, 32'h0000_000a);
		req_valid = 1'b1;
		req_addr = 32'hc0de_0000;
		step(1);
		req_valid = 1'b0;
		chk_word(bus_addr, 32'h5a5a_1234);
		for (i = 0; i < 20 && rvalid !== 1'b1; i++)
			step(1);
		chk_word(i, {28'h0, d});
		chk_word(rdata, 32'h1234_5a5a);
		step(1);
		chk_word({rvalid, stalled}, 32'h0);
	endtask : t_hold
	// store takes a check cycle then a write cycle
	task automatic t_store();
		req_valid = 1'b1;
		req_store = 1'b1;
		req_addr = 32'h3000_0010;
		step(1);
		req_valid = 1'b0;
		req_store = 1'b0;
		chk_word({bus_write, ready, phase}, 32'h1);
		step(1);
		chk_word({bus_write, bus_wdata[30:0]}, 32'hbeef_0001);
		step(2);
	endtask : t_store
	// each side voids the access with its own signal
	task automatic t_void();
		req_valid = 1'b1;
		req_fault = 1'b1;
		step(1);
		req_valid = 1'b0;
		req_fault = 1'b0;
		fpc_fault = 1'b1;
		chk_word({core_void, fpc_void}, 32'h2);
		step(1);
		fpc_fault = 1'b0;
		chk_word({core_void, fpc_void}, 32'h1);
	endtask : t_void
	// stretcher: free run, two wait states, then a stretch cut by a void
	task automatic t_stretch();
		sc_count = 0;
		step(4);
		chk_word(sc_count, 32'h4);
		sc_count = 0;
		start = 1'b1;
		step(1);
		start = 1'b0;
		step(3);
		chk_word(sc_count, 32'h2);
		sc_count = 0;
		start = 1'b1;
		step(1);
		start = 1'b0;
		req_fault = 1'b1;
		step(1);
		req_fault = 1'b0;
		step(2);
		chk_word(sc_count, 32'h3);
	endtask : t_stretch
	//////////////////////////////////////////////////////////////////////
	// clock, reset and scenario order
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial
	begin
		{req_valid, req_store, req_fault, fpc_fault, start} = 5'h0;
		req_addr = 32'h0;
		req_stat = 8'h0b;
		req_wdata = 32'h3eef_0001;
		dly = 4'h0;
		sys_rst = 1'b1;
		step(12);
		chk_word({ready, bus_valid, stalled, rvalid, phase}, 32'h20);
		sys_rst = 1'b0;
		t_back();
		step(1);
		t_hold(4'h2);
		t_hold(4'h7);
		t_store();
		t_void();
		t_stretch();
		close_out();
	end
	// watchdog well beyond the fifty or so cycles the scenarios need
	initial
	begin
		#20000;
		miscompares++;
		close_out();
	end
endmodule : wsc_core_port_bench
`default_nettype wire
